/* src/parallel_port.sv */
// parallel port control and mode registers with master transfer sequencer
`timescale 1ns/10ps

// What this block does
// - enable clear blocks all external access
// - stop-in-idle halts port during idle mode
// - multiplex field picks address/data layout
// - write strobe pin enable hands pin over
// - read strobe pin enable hands pin over
// - shared pin: chip select or address 14
// - latch polarity sets both latch strobes
// - chip select polarity sets its level
// - write polarity: write or enable strobe
// - read polarity: read or read/write strobe
// - pin settings ignored when pins carry address
// - busy flag shows master transfer in progress
// - interrupt mode selects port event source
// - error event raised regardless of mode
// - increment mode steps address or buffers
// - chip select bit excluded from stepping
// - mode field selects master or slave
// - setup wait sets setup and address phase
// - zero strobe wait forces fixed setup/hold
// - clear, set, invert aliases on control, mode and address
// - strobe wait stretches strobe 1 to 16
// - hold wait after strobe, read one less
module parallel_port (
  // clock, reset, freeze
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic idle_mode,
  // axi4-lite write
  input wire logic [parallel_port_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [parallel_port_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // data lines
  input wire logic [7:0] data_lines_in,
  output logic [7:0] data_lines_out,
  output logic data_lines_oe,
  // address and control pins
  output logic [10:2] addr_lines,
  output logic addr_latch_low,
  output logic addr_latch_high,
  output logic chip_select_out,
  output logic read_strobe,
  output logic read_strobe_oe,
  output logic write_strobe,
  output logic write_strobe_oe,
  // slave side inputs
  input wire logic slave_cs_in,
  input wire logic slave_rd_in,
  input wire logic slave_wr_in,
  input wire logic [1:0] slave_addr_in,
  // events
  output logic port_event,
  output logic port_error_event
);

  // ********************************************
  // helpers
  // ********************************************
  function automatic logic [15:0] reg_update(input logic [15:0] old, input logic [15:0] d,
                                             input logic [1:0] op, input logic [15:0] wmask,
                                             input logic [15:0] bmask);
    logic [15:0] m;
    logic [15:0] v;
    m = wmask & bmask;
    case (op)
      parallel_port_pkg::OP_CLEAR: v = old & ~d;
      parallel_port_pkg::OP_SET: v = old | d;
      parallel_port_pkg::OP_INVERT: v = old ^ d;
      default: v = d;
    endcase
    reg_update = (old & ~m) | (v & m);
  endfunction

  function automatic logic addr_mapped(input logic [parallel_port_pkg::ADDR_W-1:0] a);
    addr_mapped = (a[1:0] == 2'h0) && ((a[7:4] < parallel_port_pkg::IDX_XFER) ||
                  ((a[7:4] == parallel_port_pkg::IDX_XFER) && (a[3:2] == parallel_port_pkg::OP_WRITE)));
  endfunction

  // asserted level of a pin with polarity bit: 1 = active high
  function automatic logic act_level(input logic on, input logic pol);
    act_level = ~(on ^ pol);
  endfunction

  // ********************************************
  // state
  // ********************************************
  logic [15:0] control_r;
  logic [15:0] mode_r;
  logic [15:0] address_r;
  logic [7:0] wbyte_r;
  logic [7:0] rbyte_r;
  logic rd_r;
  logic [4:0] cnt_r;
  parallel_port_pkg::xfer_state_type state_r;
  parallel_port_pkg::xfer_state_type state_nxt;
  logic [4:0] cnt_nxt;
  logic aw_got_r;
  logic w_got_r;
  logic [parallel_port_pkg::ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic slave_acc_r;
  logic [1:0] buf_idx_r;

  // ********************************************
  // field decode
  // ********************************************
  wire port_on = control_r[parallel_port_pkg::CTRL_ON];
  wire [1:0] mux_sel = control_r[parallel_port_pkg::CTRL_MUX_LO +: 2];
  wire [1:0] csf = control_r[parallel_port_pkg::CTRL_CSF_LO +: 2];
  wire addr_latch_polarity = control_r[parallel_port_pkg::CTRL_ALP];
  wire csp = control_r[parallel_port_pkg::CTRL_CSP];
  wire write_strobe_polarity = control_r[parallel_port_pkg::CTRL_WRITE_STROBE_POLARITY];
  wire read_strobe_polarity = control_r[parallel_port_pkg::CTRL_READ_STROBE_POLARITY];
  wire [1:0] irqm = mode_r[parallel_port_pkg::MODE_IRQM_LO +: 2];
  wire [1:0] incm = mode_r[parallel_port_pkg::MODE_INCM_LO +: 2];
  wire [1:0] msel = mode_r[parallel_port_pkg::MODE_SEL_LO +: 2];
  wire [1:0] waitb = mode_r[parallel_port_pkg::MODE_WAITB_LO +: 2];
  wire [3:0] waitm = mode_r[parallel_port_pkg::MODE_WAITM_LO +: 4];
  wire [1:0] waite = mode_r[parallel_port_pkg::MODE_WAITE_LO +: 2];
  wire is_master = msel[1];
  wire cs_mode = (csf == parallel_port_pkg::CSF_CHIP_SELECT);
  // stop-in-idle freezes the sequencer and slave access detection; the bus stays reachable
  wire halted = control_r[parallel_port_pkg::CTRL_STOP_IN_IDLE] & idle_mode;
  wire run = ce & ~halted;
  wire busy = (state_r != parallel_port_pkg::ST_IDLE);

  // ********************************************
  // phase lengths
  // ********************************************
  wire fast = (waitm == 4'h0);
  wire [4:0] setup_len = fast ? 5'h01 : {3'h0, waitb} + 5'h01;
  wire [4:0] strobe_len = {1'b0, waitm} + 5'h01;
  wire [4:0] hold_len = fast ? {4'h0, ~rd_r} : ({3'h0, waite} + {4'h0, ~rd_r});

  // ********************************************
  // axi4-lite slave
  // ********************************************
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire wr_ok = addr_mapped(aw_addr_r);
  wire [3:0] wr_idx = aw_addr_r[7:4];
  wire [1:0] wr_op = aw_addr_r[3:2];
  wire [15:0] wr_d = w_data_r[15:0];
  wire [15:0] wr_bmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire wr_control = do_write & wr_ok & (wr_idx == parallel_port_pkg::IDX_CONTROL);
  wire wr_mode = do_write & wr_ok & (wr_idx == parallel_port_pkg::IDX_MODE);
  wire wr_address = do_write & wr_ok & (wr_idx == parallel_port_pkg::IDX_ADDRESS);
  // a command needs the low byte and the direction byte together
  wire start_req = do_write & wr_ok & (wr_idx == parallel_port_pkg::IDX_XFER) & (&w_strb_r[1:0]);
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire [3:0] rd_idx = s_axi_araddr[7:4];
  wire [15:0] rd_val = (rd_idx == parallel_port_pkg::IDX_CONTROL) ? control_r :
                       (rd_idx == parallel_port_pkg::IDX_MODE) ? {busy, mode_r[14:0]} :
                       (rd_idx == parallel_port_pkg::IDX_ADDRESS) ? address_r :
                       {busy, 7'h00, rbyte_r};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= parallel_port_pkg::RESP_OKAY;
    end else if (ce) begin
      if (aw_hs) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? parallel_port_pkg::RESP_OKAY : parallel_port_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= parallel_port_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= addr_mapped(s_axi_araddr) ? {16'h0000, rd_val} : 32'h0000_0000;
        s_axi_rresp <= addr_mapped(s_axi_araddr) ? parallel_port_pkg::RESP_OKAY :
                       parallel_port_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ********************************************
  // transfer sequencer
  // ********************************************
  wire go = start_req & port_on & is_master & ~busy;
  wire phase_end = (cnt_r == 5'h00);
  wire finish = run & phase_end & (((state_r == parallel_port_pkg::ST_STROBE) && (hold_len == 5'h00)) ||
                (state_r == parallel_port_pkg::ST_HOLD));
  wire strobe_end = run & phase_end & (state_r == parallel_port_pkg::ST_STROBE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r - 5'h01;
    case (state_r)
      parallel_port_pkg::ST_IDLE: begin
        cnt_nxt = setup_len - 5'h01;
        if (go) begin
          // optional address phase, then setup, strobe, hold
          state_nxt = (mux_sel == parallel_port_pkg::MUX_SEPARATE) ? parallel_port_pkg::ST_SETUP :
                      parallel_port_pkg::ST_ADDR_LO;
        end
      end
      parallel_port_pkg::ST_ADDR_LO: begin
        if (phase_end) begin
          cnt_nxt = setup_len - 5'h01;
          state_nxt = (mux_sel == parallel_port_pkg::MUX_FULL) ? parallel_port_pkg::ST_ADDR_HI :
                      parallel_port_pkg::ST_SETUP;
        end
      end
      parallel_port_pkg::ST_ADDR_HI: begin
        if (phase_end) begin
          cnt_nxt = setup_len - 5'h01;
          state_nxt = parallel_port_pkg::ST_SETUP;
        end
      end
      parallel_port_pkg::ST_SETUP: begin
        if (phase_end) begin
          cnt_nxt = strobe_len - 5'h01;
          state_nxt = parallel_port_pkg::ST_STROBE;
        end
      end
      parallel_port_pkg::ST_STROBE: begin
        if (phase_end) begin
          cnt_nxt = hold_len - 5'h01;
          state_nxt = (hold_len == 5'h00) ? parallel_port_pkg::ST_IDLE : parallel_port_pkg::ST_HOLD;
        end
      end
      parallel_port_pkg::ST_HOLD: begin
        if (phase_end) begin
          state_nxt = parallel_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = parallel_port_pkg::ST_IDLE;
      end
    endcase
    // disabling aborts at once so no further pin activity follows
    if (!port_on) begin
      state_nxt = parallel_port_pkg::ST_IDLE;
    end
  end

  // step address bits 10:2 and 14 as one counter; bit 14 stays put when it is chip select
  wire [9:0] step_src = {address_r[parallel_port_pkg::ADDR_BIT14], address_r[10:2]};
  wire [9:0] step_val = (incm == parallel_port_pkg::INC_UP) ? step_src + 10'h001 :
                        (incm == parallel_port_pkg::INC_DOWN) ? step_src - 10'h001 : step_src;
  wire [15:0] stepped = {1'b0, cs_mode ? address_r[14] : step_val[9], 3'h0, step_val[8:0],
                         address_r[1:0]};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= parallel_port_pkg::ST_IDLE;
      cnt_r <= 5'h00;
      rd_r <= 1'b0;
      wbyte_r <= 8'h00;
      rbyte_r <= 8'h00;
    end else if (run) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (go) begin
        rd_r <= w_data_r[parallel_port_pkg::XFER_READ];
        wbyte_r <= w_data_r[7:0];
      end
      if (strobe_end & rd_r) begin
        rbyte_r <= data_lines_in;
      end
    end
  end

  // ********************************************
  // configuration registers
  // ********************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      control_r <= parallel_port_pkg::CONTROL_RESET;
      mode_r <= parallel_port_pkg::MODE_RESET;
      address_r <= parallel_port_pkg::ADDRESS_RESET;
    end else if (ce) begin
      if (wr_control) begin
        control_r <= reg_update(control_r, wr_d, wr_op, parallel_port_pkg::CONTROL_WMASK, wr_bmask);
      end
      if (wr_mode) begin
        mode_r <= reg_update(mode_r, wr_d, wr_op, parallel_port_pkg::MODE_WMASK, wr_bmask);
      end
      // software write wins over the automatic step in the same cycle
      if (wr_address) begin
        address_r <= reg_update(address_r, wr_d, wr_op, parallel_port_pkg::ADDRESS_WMASK, wr_bmask);
      end else if (finish) begin
        address_r <= stepped;
      end
    end
  end

  // ********************************************
  // slave access detection
  // ********************************************
  wire slave_sel = act_level(slave_cs_in, csp);
  wire slave_acc = slave_sel & (act_level(slave_rd_in, read_strobe_polarity) | act_level(slave_wr_in, write_strobe_polarity));
  wire slave_start = slave_acc & ~slave_acc_r & port_on & ~is_master & ~halted;
  wire buffered = (msel == parallel_port_pkg::SEL_LEGACY) & (incm == parallel_port_pkg::INC_BUFFER);
  wire buf3_hit = slave_start & (((msel == parallel_port_pkg::SEL_ADDR_SLAVE) &&
                  (slave_addr_in == parallel_port_pkg::LAST_BUFFER)) ||
                  (buffered && (buf_idx_r == parallel_port_pkg::LAST_BUFFER)));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      slave_acc_r <= 1'b0;
      buf_idx_r <= 2'h0;
    end else if (ce) begin
      slave_acc_r <= slave_acc;
      if (!buffered) begin
        buf_idx_r <= 2'h0;
      end else if (slave_start) begin
        buf_idx_r <= buf_idx_r + 2'h1;
      end
    end
  end

  // ********************************************
  // pin and event outputs
  // ********************************************
  wire in_lo = (state_r == parallel_port_pkg::ST_ADDR_LO);
  wire in_hi = (state_r == parallel_port_pkg::ST_ADDR_HI);
  wire in_strobe = (state_r == parallel_port_pkg::ST_STROBE);
  wire mux_sep = (mux_sel == parallel_port_pkg::MUX_SEPARATE);
  wire upper_on_pins = mux_sep | (mux_sel == parallel_port_pkg::MUX_LOW_SPLIT);
  wire [7:0] data_nxt = in_lo ? address_r[7:0] :
                        in_hi ? {1'b0, address_r[14], 3'h0, address_r[10:8]} : wbyte_r;
  wire data_oe_nxt = in_lo | in_hi | (busy & ~rd_r);
  wire [10:2] addr_nxt = {upper_on_pins ? address_r[10:8] : 3'h0, mux_sep ? address_r[7:2] : 6'h00};
  // with separate lines the latch pins carry address bits, so polarity is moot
  wire latch_lo_nxt = mux_sep ? address_r[0] : act_level(in_lo, addr_latch_polarity);
  wire latch_hi_nxt = mux_sep ? address_r[1] : act_level(in_hi, addr_latch_polarity);
  wire cs_nxt = cs_mode ? act_level(busy, csp) : (upper_on_pins & address_r[14]);
  wire m1 = (msel == parallel_port_pkg::SEL_MASTER1);
  wire rd_pin_nxt = m1 ? act_level(busy & rd_r, read_strobe_polarity) : act_level(in_strobe & rd_r, read_strobe_polarity);
  wire wr_pin_nxt = m1 ? act_level(in_strobe, write_strobe_polarity) : act_level(in_strobe & ~rd_r, write_strobe_polarity);
  wire drive_pins = port_on & is_master;
  wire cycle_evt = finish & (irqm == parallel_port_pkg::IRQ_CYCLE);
  wire buf_evt = buf3_hit & (irqm == parallel_port_pkg::IRQ_BUF3);
  wire error_evt = start_req & ~go;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_lines_out <= 8'h00;
      data_lines_oe <= 1'b0;
      addr_lines <= '0;
      addr_latch_low <= 1'b0;
      addr_latch_high <= 1'b0;
      chip_select_out <= 1'b0;
      read_strobe <= 1'b0;
      write_strobe <= 1'b0;
      read_strobe_oe <= 1'b0;
      write_strobe_oe <= 1'b0;
      port_event <= 1'b0;
      port_error_event <= 1'b0;
    end else if (ce) begin
      data_lines_out <= data_nxt;
      data_lines_oe <= drive_pins & data_oe_nxt;
      addr_lines <= addr_nxt;
      addr_latch_low <= latch_lo_nxt;
      addr_latch_high <= latch_hi_nxt;
      chip_select_out <= cs_nxt;
      read_strobe <= rd_pin_nxt;
      write_strobe <= wr_pin_nxt;
      read_strobe_oe <= drive_pins & control_r[parallel_port_pkg::CTRL_RDEN];
      write_strobe_oe <= drive_pins & control_r[parallel_port_pkg::CTRL_WREN];
      port_event <= cycle_evt | buf_evt;
      port_error_event <= error_evt;
    end
  end

endmodule

/* src/parallel_port_pkg.sv */
// constants, field positions and types shared by the parallel port control block
package parallel_port_pkg;

  // ********************************************
  // register map (index in byte address bits 7:4), alias operations (bits 3:2)
  // ********************************************
  localparam int ADDR_W = 8;
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_MODE = 4'h1;
  localparam logic [3:0] IDX_ADDRESS = 4'h2;
  localparam logic [3:0] IDX_XFER = 4'h3;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_CLEAR = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;
  localparam logic [1:0] OP_INVERT = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************************
  // writable masks and reset values
  // ********************************************
  localparam logic [15:0] CONTROL_WMASK = 16'hBFEB;
  localparam logic [15:0] MODE_WMASK = 16'h7BFF;
  localparam logic [15:0] ADDRESS_WMASK = 16'h47FF;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] ADDRESS_RESET = 16'h0000;

  // ********************************************
  // field positions
  // ********************************************
  localparam int CTRL_ON = 15;
  localparam int CTRL_STOP_IN_IDLE = 13;
  localparam int CTRL_MUX_LO = 11;
  localparam int CTRL_WREN = 9;
  localparam int CTRL_RDEN = 8;
  localparam int CTRL_CSF_LO = 6;
  localparam int CTRL_ALP = 5;
  localparam int CTRL_CSP = 3;
  localparam int CTRL_WRITE_STROBE_POLARITY = 1;
  localparam int CTRL_READ_STROBE_POLARITY = 0;
  localparam int MODE_BUSY = 15;
  localparam int MODE_IRQM_LO = 13;
  localparam int MODE_INCM_LO = 11;
  localparam int MODE_SEL_LO = 8;
  localparam int MODE_WAITB_LO = 6;
  localparam int MODE_WAITM_LO = 2;
  localparam int MODE_WAITE_LO = 0;
  localparam int ADDR_BIT14 = 14;
  localparam int XFER_READ = 8;

  // ********************************************
  // field codes
  // ********************************************
  localparam logic [1:0] MUX_SEPARATE = 2'h0;
  localparam logic [1:0] MUX_LOW_SPLIT = 2'h1;
  localparam logic [1:0] MUX_FULL = 2'h2;
  localparam logic [1:0] MUX_LOW_ONLY = 2'h3;
  localparam logic [1:0] CSF_CHIP_SELECT = 2'h2;
  localparam logic [1:0] IRQ_CYCLE = 2'h1;
  localparam logic [1:0] IRQ_BUF3 = 2'h2;
  localparam logic [1:0] INC_UP = 2'h1;
  localparam logic [1:0] INC_DOWN = 2'h2;
  localparam logic [1:0] INC_BUFFER = 2'h3;
  localparam logic [1:0] SEL_LEGACY = 2'h0;
  localparam logic [1:0] SEL_ADDR_SLAVE = 2'h1;
  localparam logic [1:0] SEL_MASTER2 = 2'h2;
  localparam logic [1:0] SEL_MASTER1 = 2'h3;
  localparam logic [1:0] LAST_BUFFER = 2'h3;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR_LO, ST_ADDR_HI, ST_SETUP, ST_STROBE, ST_HOLD} xfer_state_type;

endpackage

/* tb/parallel_port_chk.sv */
// assertions on the parallel port bus handshakes and event pulses
`timescale 1ns/10ps
module parallel_port_chk (
  // clock, reset, clock enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // register bus handshakes
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // events
  input wire logic port_event,
  input wire logic port_error_event
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  a_write_answer: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_aw_blocked: assert property (ce && s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write accepted while one open");
  a_ar_blocked: assert property (ce && s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("second read accepted while one open");
  a_event_pulse: assert property (port_event |=> !port_event)
    else $error("port event longer than one cycle");
  a_error_pulse: assert property (port_error_event |=> !port_error_event)
    else $error("error event longer than one cycle");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_event: cover property (port_event);
  c_error: cover property (port_error_event);
endmodule

/* tb/parallel_device.sv */
// behavioural external byte-wide device on the parallel port pins
`timescale 1ns/10ps
module parallel_device (
  // clock and strobes
  input wire logic ref_clk,
  input wire logic read_strobe, read_strobe_oe, write_strobe, write_strobe_oe,
  // data lines
  input wire logic data_lines_oe,
  input wire logic [7:0] data_lines_out,
  output logic [7:0] data_lines_in,
  output logic [7:0] mem_r = 8'h00
);
  logic [7:0] last_r = 8'h00;
  wire rd_act = read_strobe && read_strobe_oe;
  always @(posedge ref_clk) begin
    if (write_strobe && write_strobe_oe && data_lines_oe) begin
      mem_r <= data_lines_out;
    end
    last_r <= data_lines_in;
  end
  // a released bus toggles so a stale byte can never pass as read data
  assign data_lines_in = rd_act ? mem_r : ~last_r;
endmodule

/* tb/test_parallel_port.sv */
// self-checking bench for the parallel port control block
`timescale 1ns/10ps
module test_parallel_port;
  typedef struct packed {logic [7:0] wa; logic [31:0] wd; logic [1:0] wr; logic [7:0] ra; logic [31:0] rd;} row_type;
  logic ref_clk = 1'b0, sys_rst = 1'b1, idle_mode = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, data_lines_in, data_lines_out, addr_lines_x, mem_r;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, data_lines_oe;
  logic read_strobe, read_strobe_oe, write_strobe, write_strobe_oe, chip_select_out, port_event, port_error_event;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] slv = 5'h00;
  int mismatches = 0, n_compared = 0, cyc = 0, cnt [5] = '{default: 0}, base [5];
  row_type rows [8] = '{'{8'h00, 32'hFFFFFFFF, 2'h0, 8'h00, 32'h0000BFEB}, '{8'h04, 32'h8000, 2'h0, 8'h00, 32'h3FEB},
    '{8'h08, 32'h8000, 2'h0, 8'h00, 32'hBFEB}, '{8'h0C, 32'hFFFF, 2'h0, 8'h00, 32'h0},
    '{8'h10, 32'hFFFFFFFF, 2'h0, 8'h10, 32'h7BFF}, '{8'h20, 32'hFFFFFFFF, 2'h0, 8'h20, 32'h47FF},
    '{8'h24, 32'hFFFFFFFF, 2'h0, 8'h20, 32'h0}, '{8'h41, 32'h1, parallel_port_pkg::RESP_SLVERR, 8'h10, 32'h7BFF}};
  parallel_port parallel_port_i (.ref_clk, .sys_rst, .ce(1'b1), .idle_mode, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .data_lines_in, .data_lines_out, .data_lines_oe, .addr_lines(), .addr_latch_low(),
    .addr_latch_high(), .chip_select_out, .read_strobe, .read_strobe_oe, .write_strobe, .write_strobe_oe,
    .slave_cs_in(slv[4]), .slave_rd_in(slv[3]), .slave_wr_in(slv[2]), .slave_addr_in(slv[1:0]), .port_event,
    .port_error_event);
  parallel_device parallel_device_i (.ref_clk, .read_strobe, .read_strobe_oe, .write_strobe, .write_strobe_oe,
    .data_lines_oe, .data_lines_out, .data_lines_in, .mem_r);
  always #5 ref_clk = ~ref_clk;
  // ****************************************
  // pin activity counters and timeout
  // ****************************************
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    cnt <= '{cnt[0] + int'(write_strobe), cnt[1] + int'(read_strobe), cnt[2] + int'(chip_select_out),
      cnt[3] + int'(port_event), cnt[4] + int'(port_error_event)};
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    got = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // polls status until busy clears, bounded
  task automatic settle;
    rd(8'h30);
    for (int k = 0; k < 20 && got[15] !== 1'b0; k++) rd(8'h30);
  endtask
  task automatic cnts(input int e [5]);
    for (int i = 0; i < 5; i++) chk($sformatf("pin count %0d", i), 32'(e[i]), 32'(cnt[i] - base[i]));
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 16));
      chk("reset value", 32'h0, got);
    end
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      chk("write resp", 32'(rows[i].wr), 32'(resp));
      rd(rows[i].ra);
      chk("read back", rows[i].rd, got);
    end
    $display("register table done");
    wr(8'h00, 32'h838B);
    wr(8'h10, 32'h2A49);
    wr(8'h20, 32'h47FC);
    base = cnt;
    wr(8'h30, 32'hA5);
    wr(8'h30, 32'hA5);
    settle();
    cnts('{3, 0, 7, 1, 1});
    chk("device byte", 32'hA5, 32'(mem_r));
    rd(8'h20);
    chk("address wrap", 32'h4000, got);
    $display("write transfer done");
    base = cnt;
    wr(8'h30, 32'h100);
    settle();
    cnts('{0, 3, 6, 1, 0});
    chk("status", 32'h00A5, got);
    rd(8'h20);
    chk("address step", 32'h4004, got);
    $display("read transfer done");
    wr(8'h10, 32'h2A41);
    base = cnt;
    wr(8'h30, 32'h3C);
    settle();
    cnts('{1, 0, 3, 1, 0});
    chk("device byte", 32'h3C, 32'(mem_r));
    $display("fixed wait done");
    wr(8'h04, 32'h8000);
    base = cnt;
    wr(8'h30, 32'h11);
    repeat (3) @(posedge ref_clk);
    cnts('{0, 0, 0, 0, 1});
    chk("strobe oe", 32'h0, 32'({read_strobe_oe, write_strobe_oe}));
    $display("disabled port done");
    wr(8'h10, 32'h4100);
    wr(8'h00, 32'h808B);
    base = cnt;
    slv <= 5'h1B;
    repeat (4) @(posedge ref_clk);
    slv <= 5'h00;
    repeat (3) @(posedge ref_clk);
    cnts('{0, 0, 0, 1, 0});
    $display("slave access done");
    close_out();
  end
endmodule
bind parallel_port parallel_port_chk parallel_port_chk_i (.ref_clk, .sys_rst, .ce, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .port_event, .port_error_event);
